// ### hdl/tpg_ctrl.sv
// command-driven streaming test pattern generator, control and datapath
// assumes a 100 MHz ref_clk, active-low async resetn, and a sink on the
// stream side that obeys ready/valid; control bits are plain ports
//
// Operation
// R1: disable halts output, commands still queued
// R2: enable setting readable back
// R3: throttle holds values zero through 256
// R4: average rate equals throttle over 256
// R5: throttle setting readable back
// R6: busy while sending or commands pending
// R7: fill level equals commands held
// R8: commands enter on separate command port
// R9: one fragment per command, commanded channel
// R10: flags send or hide packet markers
// R11: command error value driven on stream
// R12: data words xored with command mask
// R13: host keeps markers consistent per channel
// R14: non-last segments multiple of beat width
// R15: no packets: no markers, whole beats
// R16: throttle compared with pseudorandom each cycle
// R17: zero stops, 256 moves every cycle
// R18: full command fifo stalls command port
module tpg_ctrl import tpg_pkg::*; (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // control and status
    input wire logic ctl_enable,
    input wire logic [TPG_THR_W-1:0] ctl_throttle,
    output logic sts_enable,
    output logic [TPG_THR_W-1:0] sts_throttle,
    output logic sts_busy,
    output logic [TPG_LVL_W-1:0] sts_fill_level,
    // command port
    input wire logic [TPG_CMD_W-1:0] cmd_data,
    input wire logic cmd_valid,
    output logic cmd_ready,
    // stream source
    output logic [TPG_DATA_W-1:0] st_data,
    output logic st_valid,
    input wire logic st_ready,
    output logic [TPG_CHAN_W-1:0] st_channel,
    output logic st_sop,
    output logic st_eop,
    output logic [TPG_EMPTY_W-1:0] st_empty,
    output logic [TPG_ERR_W-1:0] st_error
);
    // all registered state of the block except the reset release pair
    typedef struct packed {
        tpg_state_type state;
        tpg_cmd_type cmd;
        logic [TPG_SIZE_W-1:0] left;     // symbols still to send
        logic first;                     // next beat starts the fragment
        logic [TPG_DATA_W-1:0] pattern;  // running pattern counter
        logic [15:0] lfsr;
        logic enable;
        logic [TPG_THR_W-1:0] throttle;
        logic busy;
        logic [TPG_LVL_W-1:0] level;
        logic cmd_ready;
        logic [TPG_DATA_W-1:0] data;
        logic valid;
        logic [TPG_CHAN_W-1:0] channel;
        logic sop;
        logic eop;
        logic [TPG_EMPTY_W-1:0] empty;
        logic [TPG_ERR_W-1:0] error;
    } tpg_ctrl_state_type;

    tpg_ctrl_state_type s_q, s_d;
    logic rst_n;                       // synchronised reset
    // reset release pair, kept out of the state struct so that the struct
    // has exactly one clocked driver
    logic [1:0] rst_sync_q;
    tpg_cmd_type fifo_out;
    logic fifo_valid, fifo_pop, fifo_in_ready;
    logic [TPG_LVL_W-1:0] fifo_level;
    logic [TPG_CMD_W-1:0] fifo_out_bits;

    // galois lfsr step, one pseudorandom word per cycle
    function automatic logic [15:0] lfsr_step(input logic [15:0] v);
        lfsr_step = v[0] ? ((v >> 1) ^ TPG_LFSR_TAPS) : (v >> 1);
    endfunction : lfsr_step

    // reset release through two flops; only the second is used
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // command fifo: stalls the command port when full
    tpg_fifo #(
        .WIDTH(TPG_CMD_W),
        .DEPTH(TPG_FIFO_DEPTH),
        .LVL_W(TPG_LVL_W)
    ) u_cmd_fifo (
        .clk(ref_clk),
        .rst_n(rst_n),
        .in_data(cmd_data),             // R8
        .in_valid(cmd_valid && s_q.cmd_ready),
        .in_ready(fifo_in_ready),
        .out_data(fifo_out_bits),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .level(fifo_level)
    );
    assign fifo_out = tpg_cmd_type'(fifo_out_bits);

    // next-state logic: command fetch, throttle, beat generation
    always_comb begin
        logic go;
        logic [TPG_SIZE_W-1:0] take;
        logic [TPG_THR_W-1:0] rnd;
        go = 1'b0;
        take = '0;
        rnd = '0;
        s_d = s_q;
        fifo_pop = 1'b0;
        s_d.lfsr = lfsr_step(s_q.lfsr);
        // sampled controls, read back as plain status
        s_d.enable = ctl_enable;                        // R2
        // values above 256 are clipped to full rate
        s_d.throttle = (ctl_throttle > TPG_THR_RESET) ?
                       TPG_THR_RESET : ctl_throttle;    // R3 R5
        // registered ready: fifo accepted only while the flop said room;
        // one slot of margin covers the write landing next edge
        s_d.cmd_ready = (fifo_level < TPG_LVL_W'(TPG_FIFO_DEPTH - 1)) ||
                        (fifo_level == TPG_LVL_W'(TPG_FIFO_DEPTH - 1) &&
                         !(cmd_valid && s_q.cmd_ready));  // R18
        // a random byte below the throttle lets one beat move
        rnd = {1'b0, s_q.lfsr[7:0]};
        go = s_q.enable && (rnd < s_q.throttle);       // R1 R4 R16 R17
        // output beat retires when the sink takes it
        if (s_q.valid && st_ready) begin
            s_d.valid = 1'b0;
        end
        unique case (s_q.state)
            TPG_IDLE: begin
                // fetch next command only while enabled; while disabled it waits queued
                if (fifo_valid && s_q.enable) begin    // R1
                    fifo_pop = 1'b1;
                    s_d.cmd = fifo_out;
                    s_d.left = fifo_out.size;
                    s_d.first = 1'b1;
                    s_d.state = TPG_SEND;
                end
            end
            TPG_SEND: begin
                if (go && (!s_q.valid || st_ready)) begin
                    take = (s_q.left > TPG_SIZE_W'(TPG_SYMS)) ?
                           TPG_SIZE_W'(TPG_SYMS) : s_q.left;
                    s_d.valid = 1'b1;
                    s_d.channel = s_q.cmd.channel;     // R9
                    s_d.error = s_q.cmd.error;         // R11
                    s_d.data = s_q.pattern ^ s_q.cmd.mask;  // R12
                    s_d.pattern = s_q.pattern + TPG_DATA_W'(1);
                    s_d.sop = s_q.first && s_q.cmd.send_sop &&
                              !s_q.cmd.flag_hide_packet_start;  // R10
                    s_d.eop = (s_q.left == take) && s_q.cmd.send_eop &&
                              !s_q.cmd.flag_hide_packet_end;    // R10
                    s_d.empty = TPG_EMPTY_W'(TPG_SIZE_W'(TPG_SYMS) - take);
                    s_d.first = 1'b0;
                    s_d.left = s_q.left - take;
                    if (s_q.left == take) begin
                        s_d.state = TPG_IDLE;          // R9
                    end
                end
                // a zero-size command ends after one cycle here, sending one beat only if go is set in it
                if (s_q.left == '0) begin
                    s_d.state = TPG_IDLE;
                end
            end
            default: begin
                s_d.state = TPG_IDLE;
            end
        endcase
        s_d.level = fifo_level;                         // R7
        s_d.busy = (s_d.state == TPG_SEND) || s_d.valid ||
                   fifo_valid;                          // R6
    end

    // single state register
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q.state <= TPG_IDLE;
            s_q.cmd <= '0;
            s_q.left <= '0;
            s_q.first <= 1'b0;
            s_q.pattern <= '0;
            s_q.lfsr <= TPG_LFSR_SEED;
            s_q.enable <= 1'b0;
            s_q.throttle <= TPG_THR_RESET;
            s_q.busy <= 1'b0;
            s_q.level <= '0;
            s_q.cmd_ready <= 1'b0;
            s_q.data <= '0;
            s_q.valid <= 1'b0;
            s_q.channel <= '0;
            s_q.sop <= 1'b0;
            s_q.eop <= 1'b0;
            s_q.empty <= '0;
            s_q.error <= '0;
        end else begin
            s_q.state <= s_d.state;
            s_q.cmd <= s_d.cmd;
            s_q.left <= s_d.left;
            s_q.first <= s_d.first;
            s_q.pattern <= s_d.pattern;
            s_q.lfsr <= s_d.lfsr;
            s_q.enable <= s_d.enable;
            s_q.throttle <= s_d.throttle;
            s_q.busy <= s_d.busy;
            s_q.level <= s_d.level;
            s_q.cmd_ready <= s_d.cmd_ready;
            s_q.data <= s_d.data;
            s_q.valid <= s_d.valid;
            s_q.channel <= s_d.channel;
            s_q.sop <= s_d.sop;
            s_q.eop <= s_d.eop;
            s_q.empty <= s_d.empty;
            s_q.error <= s_d.error;
        end
    end

    // outputs straight from flops
    assign sts_enable = s_q.enable;
    assign sts_throttle = s_q.throttle;
    assign sts_busy = s_q.busy;
    assign sts_fill_level = s_q.level;
    assign cmd_ready = s_q.cmd_ready;
    assign st_data = s_q.data;
    assign st_valid = s_q.valid;
    assign st_channel = s_q.channel;
    assign st_sop = s_q.sop;
    assign st_eop = s_q.eop;
    assign st_empty = s_q.empty;
    assign st_error = s_q.error;
endmodule : tpg_ctrl

// ### hdl/tpg_fifo.sv
// parameterised first-in first-out buffer with valid/ready on both sides
// assumes one clock and an asynchronous active-low reset from the parent
module tpg_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16,
    parameter int LVL_W = 5
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // fill side
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    // drain side
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready,
    // occupancy
    output logic [LVL_W-1:0] level
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [LVL_W-1:0] cnt;
    } tpg_fifo_state_type;
    tpg_fifo_state_type s_q, s_d;
    logic [WIDTH-1:0] mem [DEPTH];  // storage, no reset needed
    logic push, pop;

    assign in_ready = (s_q.cnt != LVL_W'(DEPTH));  // honest full
    assign out_valid = (s_q.cnt != '0);            // honest empty
    assign out_data = mem[s_q.rd];
    assign level = s_q.cnt;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // pointer and count update
    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.wr = s_q.wr + AW'(1);
        end
        if (pop) begin
            s_d.rd = s_q.rd + AW'(1);
        end
        s_d.cnt = s_q.cnt + LVL_W'(push) - LVL_W'(pop);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // write port kept apart so the array needs no reset
    always_ff @(posedge clk) begin
        if (push) begin
            mem[s_q.wr] <= in_data;
        end
    end
endmodule : tpg_fifo

// ### shared/tpg_pkg.sv
// shared constants and types for the test pattern generator control block
// assumes a single 100 MHz clock domain and no register bus
package tpg_pkg;
    localparam int TPG_CHAN_W = 8;      // channel number width
    localparam int TPG_SIZE_W = 16;     // fragment size in symbols
    localparam int TPG_ERR_W = 8;       // error signal width
    localparam int TPG_SYMS = 4;        // symbols per beat
    localparam int TPG_DATA_W = 32;     // beat width, eight bits a symbol
    localparam int TPG_EMPTY_W = 2;     // empty symbol count width
    localparam int TPG_THR_W = 9;       // throttle 0..256
    localparam int TPG_FIFO_DEPTH = 16; // command fifo depth
    localparam int TPG_LVL_W = 5;       // fill level 0..16
    localparam logic [TPG_THR_W-1:0] TPG_THR_RESET = 9'h100;
    localparam logic [15:0] TPG_LFSR_SEED = 16'hace1;
    localparam logic [15:0] TPG_LFSR_TAPS = 16'hb400;
    // command word: channel, size, send sop/eop, hide sop/eop, error, mask
    typedef struct packed {
        logic [TPG_CHAN_W-1:0] channel;
        logic [TPG_SIZE_W-1:0] size;
        logic send_sop;
        logic send_eop;
        logic flag_hide_packet_start;
        logic flag_hide_packet_end;
        logic [TPG_ERR_W-1:0] error;
        logic [TPG_DATA_W-1:0] mask;
    } tpg_cmd_type;
    localparam int TPG_CMD_W = $bits(tpg_cmd_type);
    typedef enum logic [1:0] {
        TPG_IDLE = 2'h0,
        TPG_SEND = 2'h1
    } tpg_state_type;
endpackage : tpg_pkg

// ### sim/tb.sv
// self-checking bench for tpg_ctrl with a stalling sink
// assumes the package constants and a 100 MHz clock
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import tpg_pkg::*;
    logic ref_clk = 0, resetn = 0, ctl_enable = 0, cmd_valid = 0;
    logic stall_en = 0, cmd_ready, st_valid, st_ready, st_sop, st_eop;
    logic sts_enable, sts_busy, ok;
    logic [TPG_THR_W-1:0] ctl_throttle = 9'h100, sts_throttle;
    logic [TPG_CMD_W-1:0] cmd_data = '0;
    logic [TPG_LVL_W-1:0] sts_fill_level;
    logic [31:0] st_data, prev;
    logic [7:0] st_channel, st_error;
    logic [1:0] st_empty;
    logic [51:0] beat_q[$], b; // retired beats, oldest first
    int errors = 0, n_compared = 0, cyc = 0, n_beats, n0, t0, k, n;
    // rows: channel, size, send sop/eop, hide sop/eop, error, mask
    tpg_cmd_type rows [5] = '{
        '{8'h01, 16'h1, 1'b1, 1'b1, 1'b0, 1'b0, 8'h00, 32'h0},
        '{8'h02, 16'h8, 1'b1, 1'b1, 1'b1, 1'b0, 8'h5a, 32'hff00ff00},
        '{8'h03, 16'hc, 1'b1, 1'b1, 1'b0, 1'b1, 8'ha5, 32'h80000001},
        '{8'h04, 16'h7, 1'b1, 1'b1, 1'b0, 1'b0, 8'h3c, 32'h0000000f},
        '{8'h05, 16'h4, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00, 32'h0}};
    tpg_ctrl DUT (.ref_clk(ref_clk), .resetn(resetn),
        .ctl_enable(ctl_enable), .ctl_throttle(ctl_throttle),
        .sts_enable(sts_enable), .sts_throttle(sts_throttle),
        .sts_busy(sts_busy), .sts_fill_level(sts_fill_level),
        .cmd_data(cmd_data), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .st_data(st_data), .st_valid(st_valid), .st_ready(st_ready),
        .st_channel(st_channel), .st_sop(st_sop), .st_eop(st_eop),
        .st_empty(st_empty), .st_error(st_error));
    tpg_sink u_sink (.ref_clk(ref_clk), .resetn(resetn),
        .stall_en(stall_en), .st_valid(st_valid), .st_ready(st_ready),
        .n_beats(n_beats));
    initial forever #5 ref_clk = ~ref_clk;
    // watchdog and beat monitor, both on the sampling edge
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            final_report();
        end
        if (st_valid === 1'b1 && st_ready === 1'b1)
            beat_q.push_back({st_data, st_channel, st_error, st_sop,
                st_eop, st_empty});
    end
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    // offers one command, holding it until taken or eight edges pass
    task automatic send(input tpg_cmd_type c);
        cmd_data <= c;
        cmd_valid <= 1'b1;
        ok = 0;
        for (int i = 0; i < 8 && !ok; i++) begin
            @(posedge ref_clk);
            ok = (cmd_ready === 1'b1);
        end
    endtask : send
    // busy rises an edge after the last command is taken, so give it a few edges first
    task automatic wait_idle();
        repeat (3) @(posedge ref_clk);
        for (int i = 0; i < 3000 && sts_busy !== 1'b0; i++)
            @(posedge ref_clk);
    endtask : wait_idle
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : final_report
    initial begin
        repeat (4) @(posedge ref_clk);
        cmp(sts_throttle, 9'h100);
        cmp(cmd_ready, 1'b0);
        resetn <= 1'b1;
        repeat (4) @(posedge ref_clk);
        ctl_enable <= 1'b1;
        stall_en <= 1'b1;
        foreach (rows[r]) begin
            send(rows[r]);
            cmp(ok, 1'b1);
        end
        cmd_valid <= 1'b0;
        wait_idle();
        foreach (rows[r]) begin
            n = (rows[r].size + 3) / 4;
            for (k = 0; k < n; k++) begin
                b = beat_q.pop_front();
                cmp(b[51:20] ^ rows[r].mask, r + k > 0 ? prev + 1 : 0);
                prev = b[51:20] ^ rows[r].mask;
                cmp(b[19:12], rows[r].channel);
                cmp(b[11:4], rows[r].error);
                cmp(b[3], k == 0 && rows[r].send_sop &&
                    !rows[r].flag_hide_packet_start);
                cmp(b[2], k == n - 1 && rows[r].send_eop &&
                    !rows[r].flag_hide_packet_end);
                cmp(b[1:0], k == n - 1 ? 2'(0 - rows[r].size) : 2'h0);
            end
        end
        cmp(beat_q.size(), 0);
        ctl_enable <= 1'b0;
        stall_en <= 1'b0;
        n0 = n_beats;
        ok = 1;
        for (k = 0; k < 20 && ok; k++) send(rows[4]);
        cmd_valid <= 1'b0;
        repeat (3) @(posedge ref_clk);
        cmp(k - 1, 16);
        cmp(sts_fill_level, 5'h10);
        cmp(sts_busy, 1'b1);
        cmp(n_beats, n0);
        cmp(sts_enable, 1'b0);
        @(posedge ref_clk);
        ctl_throttle <= 9'h0;
        ctl_enable <= 1'b1;
        repeat (50) @(posedge ref_clk);
        cmp(n_beats, n0);
        ctl_throttle <= 9'h080;
        t0 = cyc;
        wait_idle();
        cmp(n_beats - n0, 16);
        cmp((cyc - t0) inside {[24:200]}, 1'b1);
        cmp(sts_fill_level, 5'h0);
        @(posedge ref_clk);
        ctl_throttle <= 9'h1ff;
        repeat (2) @(posedge ref_clk);
        cmp(sts_throttle, 9'h100);
        ctl_throttle <= 9'h0c3;
        repeat (2) @(posedge ref_clk);
        cmp(sts_throttle, 9'h0c3);
        final_report();
    end
endmodule : tb
bind tpg_ctrl tpg_ctrl_chk u_chk (.ref_clk(ref_clk), .resetn(resetn),
    .ctl_enable(ctl_enable), .ctl_throttle(ctl_throttle),
    .sts_enable(sts_enable), .sts_throttle(sts_throttle),
    .sts_busy(sts_busy), .sts_fill_level(sts_fill_level),
    .cmd_ready(cmd_ready), .st_data(st_data), .st_valid(st_valid),
    .st_ready(st_ready), .st_eop(st_eop), .st_empty(st_empty));

// ### sim/tpg_ctrl_chk.sv
// checker for the pattern generator's control and stream ports
// assumes it is bound onto tpg_ctrl and sees only that module's ports
module tpg_ctrl_chk import tpg_pkg::*; (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // control and status
    input wire logic ctl_enable,
    input wire logic [TPG_THR_W-1:0] ctl_throttle,
    input wire logic sts_enable,
    input wire logic [TPG_THR_W-1:0] sts_throttle,
    input wire logic sts_busy,
    input wire logic [TPG_LVL_W-1:0] sts_fill_level,
    // command and stream
    input wire logic cmd_ready,
    input wire logic [TPG_DATA_W-1:0] st_data,
    input wire logic st_valid,
    input wire logic st_ready,
    input wire logic st_eop,
    input wire logic [TPG_EMPTY_W-1:0] st_empty
);
    timeunit 1ns;
    timeprecision 1ns;
    // edges since release; the design's own reset lags by two flops and
    // its readbacks need one more edge before $past sees a live input
    logic [2:0] up_q;
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) up_q <= 3'h0;
        else if (up_q != 3'h4) up_q <= up_q + 3'h1;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn || up_q != 3'h4);
    // a beat held back by the sink, a beat freshly presented, a halt
    sequence seq_stall; st_valid && !st_ready; endsequence
    sequence seq_new; st_valid && $past(!st_valid || st_ready); endsequence
    sequence seq_halted; (!ctl_enable) [*4]; endsequence
    AST_HOLD: assert property (seq_stall |=> st_valid && $stable(st_data))
        else $error("beat changed while stalled");
    AST_HALT: assert property (seq_new |-> $past(ctl_enable) ||
        $past(ctl_enable, 2) || $past(ctl_enable, 3))
        else $error("beat sent while disabled");
    AST_ZERO: assert property (seq_new |-> $past(ctl_throttle) != 9'h0 ||
        $past(ctl_throttle, 2) != 9'h0 || $past(ctl_throttle, 3) != 9'h0)
        else $error("beat sent at zero throttle");
    AST_ENRB: assert property (sts_enable == $past(ctl_enable))
        else $error("enable readback wrong");
    AST_THRB: assert property (sts_throttle == ($past(ctl_throttle) > 9'h100 ?
        9'h100 : $past(ctl_throttle)))
        else $error("throttle readback wrong");
    AST_BUSY: assert property (st_valid || (sts_fill_level != 5'h0 &&
        $past(sts_fill_level) != 5'h0) |-> sts_busy)
        else $error("busy low while work pending");
    AST_IDLE: assert property (!sts_busy |-> !st_valid)
        else $error("beat while not busy");
    AST_KEEP: assert property (seq_halted |->
        sts_fill_level >= $past(sts_fill_level))
        else $error("commands lost while disabled");
    AST_FULL: assert property (seq_halted ##0 sts_fill_level == 5'h10
        |-> !cmd_ready)
        else $error("command port open while full");
    AST_TAIL: assert property (st_valid && !st_eop |-> st_empty == 2'h0)
        else $error("partial beat before end");
endmodule : tpg_ctrl_chk

// ### sim/tpg_sink.sv
// stream sink standing in for a pattern checker
// assumes one clock; when asked, it refuses one cycle in four
module tpg_sink (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // stream handshake and beat count
    input wire logic stall_en,
    input wire logic st_valid,
    output logic st_ready,
    output int n_beats
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] ph_q; // stall phase, free running
    // counts retired beats; stalls are fixed so the run repeats exactly
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ph_q <= 2'h0;
            n_beats <= 0;
        end else begin
            ph_q <= ph_q + 2'h1;
            if (st_valid && st_ready) n_beats <= n_beats + 1;
        end
    end
    assign st_ready = !stall_en || ph_q != 2'h0;
endmodule : tpg_sink
